// [ata_notify_pkg.sv]
// constants, types and bus map for the taskfile sequencer
// assumes one system clock and an Avalon-MM master on the bus side
`default_nettype none
package ata_notify_pkg;
  // register byte offsets on the Avalon-MM slave
  localparam logic [5:0] CTRL_OFS   = 6'h00;
  localparam logic [5:0] STATUS_OFS = 6'h04;
  localparam logic [5:0] CONFIG_OFS = 6'h08;
  localparam logic [5:0] EVENT_OFS  = 6'h0c;
  localparam logic [5:0] STATE_OFS  = 6'h10;
  localparam logic [5:0] CB_OFS     = 6'h20;
  localparam logic [1:0] CB_WORDS_M1 = 2'h3;
  // control and status bit positions
  localparam int CTRL_ATACB_BIT   = 0;
  localparam int CTRL_NOTIFY_BIT  = 1;
  localparam int CTRL_ABORT_BIT   = 2;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_DONE_BIT    = 1;
  localparam int STAT_REFUSED_BIT = 2;
  // taskfile register addresses (1F0h base)
  localparam logic [2:0] TF_FEATURES = 3'h1;
  localparam logic [2:0] TF_SECCNT   = 3'h2;
  localparam logic [2:0] TF_LBA_MID  = 3'h4;
  localparam logic [2:0] TF_LBA_HIGH = 3'h5;
  localparam logic [2:0] TF_DEV_HEAD = 3'h6;
  localparam logic [2:0] TF_COMMAND  = 3'h7;
  localparam int TF_BUSY_BIT = 7;
  localparam int TF_DRQ_BIT  = 3;
  // event byte masks: reserved bits forced low
  localparam logic [7:0] FEATURES_MASK = 8'hf3;
  localparam logic [7:0] SECCNT_MASK   = 8'h0f;
  // command block layout
  localparam logic [3:0] CB_SEL_BYTE      = 4'h1;
  localparam logic [3:0] CB_DH_SRC_BYTE   = 4'h2;
  localparam int         CB_DH_SRC_BIT    = 6;
  localparam logic [3:0] CB_OVR_BYTE      = 4'h3;
  localparam int         CB_OVR_BIT       = 5;
  localparam logic [3:0] CB_ACTION2_BYTE  = 4'h4;
  localparam int         ACTION2_HOB_BIT  = 0;
  localparam logic [3:0] CB_DEV_HEAD_BYTE = 4'h5;
  localparam logic [3:0] CB_TF_FIRST      = 4'h6;
  localparam logic [3:0] CB_COMMAND_BYTE  = 4'hf;
  localparam int         SEL_DEV_HEAD     = 5;
  localparam int         SEL_COMMAND      = 6;
  // reset values, bridge device/head value and last step index
  localparam logic [7:0] STATE_RESET     = 8'h00;
  localparam logic [7:0] OPCODE_RESET    = 8'h00;
  localparam logic [7:0] DEV_HEAD_BRIDGE = 8'he0;
  localparam logic [3:0] STEP_LAST      = 4'ha;
  typedef struct packed {
    logic       write;
    logic [2:0] addr;
    logic [7:0] data;
  } tf_req_t;
  typedef enum {IDLE, WRITE_TF, POLL_STATUS, READ_MID, READ_HIGH} seq_t;
endpackage
`default_nettype wire

// [ata_taskfile_event_notification_command.sv]
// taskfile loader for vendor command blocks and the event notification command
// assumes a PIO engine on the same clock that answers each taskfile access with TF_ACK
`default_nettype none
module ata_taskfile_event_notification_command
  import ata_notify_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             TF_REQ_VALID,
  output tf_req_t          TF_REQ,
  input  wire logic        TF_ACK,
  input  wire logic [7:0]  TF_RDATA
);
  logic       ack_reg;
  logic       bus_acc;
  logic       wr_acc;
  logic [7:0] cb_reg [16];
  logic [7:0] opcode_reg;
  logic [7:0] features_reg;
  logic [3:0] power_reg;
  logic [7:0] saved_low_reg;
  logic [7:0] saved_high_reg;
  logic [7:0] new_low_reg;
  logic       done_reg;
  logic       refused_reg;
  seq_t       state_reg;
  logic       notify_reg;
  logic [3:0] step_reg;
  logic       req_valid_reg;
  tf_req_t    req_reg;
  logic       step_en;
  tf_req_t    step_req;
  logic       advance;
  logic       start_atacb;
  logic       start_notify;
  logic       abort_now;
  logic       hob_en;
  logic [7:0] sel_mask;
  logic [7:0] device_head_value;
  logic [7:0] be_mask;
  logic       status_clear;

  // one wait cycle per access, then the answer
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign bus_acc         = (AVS_READ | AVS_WRITE) & ack_reg;
  assign wr_acc          = AVS_WRITE & ack_reg;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & ~ack_reg) begin
      AVS_READDATA <= 32'h0000_0000;
      if (AVS_ADDRESS >= CB_OFS && AVS_ADDRESS[5:4] == CB_OFS[5:4]) begin
        AVS_READDATA <= {cb_reg[{AVS_ADDRESS[3:2], 2'h3}], cb_reg[{AVS_ADDRESS[3:2], 2'h2}],
                         cb_reg[{AVS_ADDRESS[3:2], 2'h1}], cb_reg[{AVS_ADDRESS[3:2], 2'h0}]};
      end else begin
        case (AVS_ADDRESS)
          STATUS_OFS: begin
            AVS_READDATA[STAT_BUSY_BIT]    <= state_reg != IDLE;
            AVS_READDATA[STAT_DONE_BIT]    <= done_reg;
            AVS_READDATA[STAT_REFUSED_BIT] <= refused_reg;
          end
          CONFIG_OFS: AVS_READDATA[7:0] <= opcode_reg;
          EVENT_OFS:  AVS_READDATA[11:0] <= {power_reg, features_reg};
          STATE_OFS:  AVS_READDATA[15:0] <= {saved_high_reg, saved_low_reg};
          default:    AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign be_mask = {8{AVS_BYTEENABLE[0]}};

  // command block storage, four words of four bytes
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      for (int i = 0; i < 16; i++) begin
        cb_reg[i] <= 8'h00;
      end
    end else if (wr_acc && AVS_ADDRESS[5:4] == CB_OFS[5:4]) begin
      for (int b = 0; b < 4; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          cb_reg[{AVS_ADDRESS[3:2], 2'(b)}] <= AVS_WRITEDATA[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      opcode_reg   <= OPCODE_RESET;
      features_reg <= 8'h00;
      power_reg    <= 4'h0;
    end else if (wr_acc && AVS_ADDRESS == CONFIG_OFS && AVS_BYTEENABLE[0]) begin
      opcode_reg <= AVS_WRITEDATA[7:0];
    end else if (wr_acc && AVS_ADDRESS == EVENT_OFS) begin
      features_reg <= (features_reg & ~be_mask) | (AVS_WRITEDATA[7:0] & be_mask
                      & FEATURES_MASK);
      if (AVS_BYTEENABLE[1]) begin
        power_reg <= AVS_WRITEDATA[11:8] & SECCNT_MASK[3:0];
      end
    end
  end

  assign start_atacb  = wr_acc && AVS_ADDRESS == CTRL_OFS && AVS_BYTEENABLE[0]
                        && AVS_WRITEDATA[CTRL_ATACB_BIT];
  assign start_notify = wr_acc && AVS_ADDRESS == CTRL_OFS && AVS_BYTEENABLE[0]
                        && AVS_WRITEDATA[CTRL_NOTIFY_BIT] && !AVS_WRITEDATA[CTRL_ATACB_BIT];
  assign abort_now    = wr_acc && AVS_ADDRESS == CTRL_OFS && AVS_BYTEENABLE[0]
                        && AVS_WRITEDATA[CTRL_ABORT_BIT];
  assign status_clear = wr_acc && AVS_ADDRESS == STATUS_OFS && AVS_BYTEENABLE[0];

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (state_reg == READ_HIGH && req_valid_reg && TF_ACK && !abort_now) begin
        done_reg <= 1'b1;
      end else if (status_clear && AVS_WRITEDATA[STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (start_notify && state_reg == IDLE && opcode_reg == 8'h00) begin
        refused_reg <= 1'b1;
      end else if (status_clear && AVS_WRITEDATA[STAT_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  assign hob_en   = cb_reg[CB_ACTION2_BYTE][ACTION2_HOB_BIT];
  assign sel_mask = cb_reg[CB_SEL_BYTE];
  assign device_head_value = cb_reg[CB_DH_SRC_BYTE][CB_DH_SRC_BIT]
    ? {cb_reg[CB_DEV_HEAD_BYTE][7:5], cb_reg[CB_OVR_BYTE][CB_OVR_BIT],
       cb_reg[CB_DEV_HEAD_BYTE][3:0]}
    : {DEV_HEAD_BRIDGE[7:5], cb_reg[CB_OVR_BYTE][CB_OVR_BIT], DEV_HEAD_BRIDGE[3:0]};

  // step table: features, four high-order, four low-order, device/head, command
  always_comb begin
    step_en  = 1'b0;
    step_req = '{write: 1'b1, addr: TF_FEATURES, data: cb_reg[CB_TF_FIRST]};
    case (step_reg)
      4'h0: begin
        step_en       = notify_reg | sel_mask[0];
        step_req.data = notify_reg ? features_reg : cb_reg[CB_TF_FIRST];
      end
      4'h1, 4'h2, 4'h3, 4'h4: begin
        step_en       = !notify_reg && sel_mask[step_reg[2:0]] && hob_en;
        step_req.addr = TF_SECCNT + (step_reg[2:0] - 3'h1);
        step_req.data = cb_reg[CB_TF_FIRST + step_reg];
      end
      4'h5, 4'h6, 4'h7, 4'h8: begin
        step_req.addr = TF_SECCNT + (step_reg[2:0] - 3'h5);
        if (notify_reg) begin
          step_en       = step_reg != 4'h6;
          step_req.data = step_reg == 4'h5 ? {4'h0, power_reg}
                        : step_reg == 4'h7 ? saved_low_reg : saved_high_reg;
        end else begin
          step_en       = sel_mask[3'(step_reg - 4'h4)];
          step_req.data = cb_reg[CB_TF_FIRST + step_reg];
        end
      end
      4'h9: begin
        step_en       = !notify_reg && sel_mask[SEL_DEV_HEAD];
        step_req.addr = TF_DEV_HEAD;
        step_req.data = device_head_value;
      end
      4'ha: begin
        step_en       = notify_reg | sel_mask[SEL_COMMAND];
        step_req.addr = TF_COMMAND;
        step_req.data = notify_reg ? opcode_reg : cb_reg[CB_COMMAND_BYTE];
      end
      default: step_en = 1'b0;
    endcase
  end

  assign advance      = req_valid_reg ? TF_ACK : !step_en;
  assign TF_REQ_VALID = req_valid_reg;
  assign TF_REQ       = req_reg;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      state_reg     <= IDLE;
      notify_reg    <= 1'b0;
      step_reg      <= 4'h0;
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else if (abort_now) begin
      state_reg     <= IDLE;
      req_valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        IDLE: begin
          step_reg <= 4'h0;
          if (start_atacb) begin
            state_reg  <= WRITE_TF;
            notify_reg <= 1'b0;
          end else if (start_notify && opcode_reg != 8'h00) begin
            state_reg  <= WRITE_TF;
            notify_reg <= 1'b1;
          end
        end
        WRITE_TF: begin
          if (!req_valid_reg && step_en) begin
            req_valid_reg <= 1'b1;
            req_reg       <= step_req;
          end else if (advance) begin
            req_valid_reg <= 1'b0;
            if (step_reg == STEP_LAST) begin
              state_reg <= notify_reg ? POLL_STATUS : IDLE;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        POLL_STATUS, READ_MID, READ_HIGH: begin
          if (!req_valid_reg) begin
            req_valid_reg <= 1'b1;
            req_reg       <= '{write: 1'b0,
                               addr: state_reg == POLL_STATUS ? TF_COMMAND
                                   : state_reg == READ_MID ? TF_LBA_MID : TF_LBA_HIGH,
                               data: 8'h00};
          end else if (TF_ACK) begin
            req_valid_reg <= 1'b0;
            if (state_reg == POLL_STATUS) begin
              if (!TF_RDATA[TF_BUSY_BIT] && !TF_RDATA[TF_DRQ_BIT]) begin
                state_reg <= READ_MID;
              end
            end else begin
              state_reg <= state_reg == READ_MID ? READ_HIGH : IDLE;
            end
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // returned state bytes kept for the next notification
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      saved_low_reg  <= STATE_RESET;
      saved_high_reg <= STATE_RESET;
      new_low_reg    <= STATE_RESET;
    end else if (req_valid_reg && TF_ACK && !abort_now) begin
      if (state_reg == READ_MID) begin
        new_low_reg <= TF_RDATA;
      end else if (state_reg == READ_HIGH) begin
        saved_low_reg  <= new_low_reg;
        saved_high_reg <= TF_RDATA;
      end
    end
  end

  bus_answer_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus access not answered after one wait cycle");

  req_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && !TF_ACK && !abort_now |=> TF_REQ_VALID && $stable(TF_REQ))
    else $error("taskfile request dropped before acknowledge");

  cmd_last_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && TF_REQ.write && TF_REQ.addr == TF_COMMAND
    |-> state_reg == WRITE_TF && step_reg == STEP_LAST)
    else $error("command written before taskfile loaded");

  opcode_use_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && notify_reg && TF_REQ.write && TF_REQ.addr == TF_COMMAND
    |-> TF_REQ.data == opcode_reg && opcode_reg != 8'h00)
    else $error("wrong notification opcode");

  notify_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    state_reg == IDLE && start_notify && !abort_now && opcode_reg == 8'h00
    |=> state_reg == IDLE ##1 state_reg == IDLE)
    else $error("notification ran while disabled");

  features_rsvd_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && notify_reg && TF_REQ.addr == TF_FEATURES
    |-> TF_REQ.data[3:2] == 2'h0 && TF_REQ.data == features_reg)
    else $error("features reserved bits set");

  seccnt_flags_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && notify_reg && TF_REQ.write && TF_REQ.addr == TF_SECCNT
    |-> TF_REQ.data == {4'h0, power_reg})
    else $error("sector count flags wrong");

  state_out_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && notify_reg && TF_REQ.write && TF_REQ.addr == TF_LBA_MID
    |-> TF_REQ.data == saved_low_reg)
    else $error("saved state not sent");

  state_reset_a: assert property (@(posedge SYS_CLK)
    !RESETN |=> saved_low_reg == 8'h00 && saved_high_reg == 8'h00)
    else $error("saved state not cleared by reset");

  dev_head_src_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && !notify_reg && TF_REQ.write && TF_REQ.addr == TF_DEV_HEAD
    && cb_reg[CB_DH_SRC_BYTE][CB_DH_SRC_BIT]
    |-> TF_REQ.data == {cb_reg[CB_DEV_HEAD_BYTE][7:5], cb_reg[CB_OVR_BYTE][CB_OVR_BIT],
                        cb_reg[CB_DEV_HEAD_BYTE][3:0]})
    else $error("device head value wrong");

  hob_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    TF_REQ_VALID && state_reg == WRITE_TF && step_reg inside {[4'h1:4'h4]} |-> hob_en)
    else $error("high-order write without enable");

  state_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    state_reg == READ_HIGH && TF_REQ_VALID && TF_ACK && !abort_now
    |=> saved_high_reg == $past(TF_RDATA) && saved_low_reg == $past(new_low_reg))
    else $error("returned state not kept");

  poll_wait_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    state_reg == POLL_STATUS && TF_REQ_VALID && TF_ACK && !abort_now
    && (TF_RDATA[TF_BUSY_BIT] || TF_RDATA[TF_DRQ_BIT]) |=> state_reg == POLL_STATUS)
    else $error("completion taken while busy or drq");
endmodule
`default_nettype wire

// [ata_drive_model.sv]
// behavioural drive answering taskfile accesses of the sequencer
// assumes requests held until the one-cycle ack, same clock as the sequencer
`default_nettype none
module ata_drive_model
  import ata_notify_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       req_valid,
  input  wire tf_req_t    req,
  output logic            ack,
  output logic      [7:0] rdata,
  input  wire logic [3:0] ack_delay,
  input  wire logic [7:0] busy_polls,
  input  wire logic [7:0] ret_low,
  input  wire logic [7:0] ret_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] wlog[$];
  logic [2:0]  rlog[$];
  logic [3:0]  wait_cnt;
  logic [7:0]  poll_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      wait_cnt <= 4'h0;
      poll_cnt <= 8'h00;
      rdata    <= 8'h5a;
    end else if (ack) begin
      ack   <= 1'b0;
      rdata <= ~rdata;
    end else if (req_valid && wait_cnt == ack_delay) begin
      ack      <= 1'b1;
      wait_cnt <= 4'h0;
      if (req.write) begin
        wlog.push_back({req.addr, req.data});
        if (req.addr == TF_FEATURES) poll_cnt <= 8'h00;
      end else begin
        rlog.push_back(req.addr);
        case (req.addr)
          TF_COMMAND: begin
            // busy first, then data-request alone, then both clear
            poll_cnt <= poll_cnt + 8'h01;
            rdata    <= (poll_cnt + 8'h01 < busy_polls) ? 8'h80 :
                        (poll_cnt < busy_polls) ? 8'h08 : 8'h50;
          end
          TF_LBA_MID:  rdata <= ret_low;
          TF_LBA_HIGH: rdata <= ret_high;
          default:     rdata <= ~rdata;
        endcase
      end
    end else begin
      // a request dropped mid-wait is simply forgotten
      wait_cnt <= req_valid ? wait_cnt + 4'h1 : 4'h0;
      rdata    <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench: Avalon-MM master tasks driving the taskfile sequencer
// assumes the drive model answers the taskfile port
`default_nettype none
module tb_top
  import ata_notify_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tf_req_valid;
  tf_req_t     tf_req;
  logic        tf_ack;
  logic [7:0]  tf_rdata;
  logic [3:0]  ack_delay = 4'h0;
  logic [7:0]  busy_polls = 8'h01;
  logic [7:0]  ret_low = 8'h00;
  logic [7:0]  ret_high = 8'h00;
  int          mismatches = 0;
  int          total_checks = 0;
  int          w_base = 0;
  int          r_base = 0;
  logic [31:0] rd;
  logic [10:0] exp_w[$];
  logic [7:0]  cb[16];

  always #2.5 sys_clk = ~sys_clk;

  ata_taskfile_event_notification_command dut_u (
    .SYS_CLK(sys_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .TF_REQ_VALID(tf_req_valid), .TF_REQ(tf_req), .TF_ACK(tf_ack), .TF_RDATA(tf_rdata));

  ata_drive_model drive_u (
    .clk(sys_clk), .rst_n(resetn), .req_valid(tf_req_valid), .req(tf_req), .ack(tf_ack),
    .rdata(tf_rdata), .ack_delay(ack_delay), .busy_polls(busy_polls), .ret_low(ret_low),
    .ret_high(ret_high));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic av_cycle(input logic [5:0] a, input logic wr, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic av_wr(input logic [5:0] a, input logic [31:0] d);
    av_cycle(a, 1'b1, d);
  endtask

  task automatic av_rd(input logic [5:0] a);
    av_cycle(a, 1'b0, 32'h0);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      av_rd(STATUS_OFS);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
    // a sequencer that never goes idle counts as a mismatch
    if (rd[STAT_BUSY_BIT] !== 1'b0) mismatches++;
  endtask

  task automatic ew(input logic [2:0] a, input logic [7:0] d);
    exp_w.push_back({a, d});
  endtask

  task automatic check_writes();
    check(32'(drive_u.wlog.size() - w_base), 32'(exp_w.size()));
    foreach (exp_w[i])
      if (w_base + i < drive_u.wlog.size())
        check({21'h0, drive_u.wlog[w_base + i]}, {21'h0, exp_w[i]});
    w_base = drive_u.wlog.size();
    exp_w.delete();
  endtask

  task automatic check_reads(input int polls);
    check(32'(drive_u.rlog.size() - r_base), 32'(polls + 2));
    for (int i = 0; i < polls + 2 && r_base + i < drive_u.rlog.size(); i++)
      check({29'h0, drive_u.rlog[r_base + i]}, {29'h0, (i < polls) ? TF_COMMAND :
            (i == polls) ? TF_LBA_MID : TF_LBA_HIGH});
    r_base = drive_u.rlog.size();
  endtask

  task automatic load_cb();
    for (int w = 0; w < 4; w++)
      av_wr(CB_OFS + 6'(4 * w), {cb[4*w+3], cb[4*w+2], cb[4*w+1], cb[4*w]});
  endtask

  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    av_rd(STATE_OFS);
    check(rd, 32'h0);
    av_rd(6'h3c);
    check(rd, 32'h0);
    // notification with opcode zero is refused and touches nothing
    av_wr(CTRL_OFS, 32'h2);
    repeat (20) @(posedge sys_clk);
    av_rd(STATUS_OFS);
    check(rd & 32'h7, 32'h4);
    check(32'(drive_u.wlog.size()), 32'h0);
    av_wr(STATUS_OFS, 32'h7);
    // first notification, reserved event bits set on purpose
    av_wr(CONFIG_OFS, 32'ha5);
    busy_polls <= 8'h03;
    ret_low    <= 8'h12;
    ret_high   <= 8'h34;
    av_wr(EVENT_OFS, 32'h0fff);
    av_wr(CTRL_OFS, 32'h2);
    wait_idle();
    check(rd & 32'h7, 32'h2);
    ew(TF_FEATURES, 8'hf3);
    ew(TF_SECCNT, 8'h0f);
    ew(TF_LBA_MID, 8'h00);
    ew(TF_LBA_HIGH, 8'h00);
    ew(TF_COMMAND, 8'ha5);
    check_writes();
    check_reads(4);
    av_rd(STATE_OFS);
    check(rd, 32'h3412);
    // abort while the drive stays busy
    av_wr(STATUS_OFS, 32'h7);
    busy_polls <= 8'hc8;
    ret_low    <= 8'h56;
    ret_high   <= 8'h78;
    av_wr(CTRL_OFS, 32'h2);
    repeat (60) @(posedge sys_clk);
    av_wr(CTRL_OFS, 32'h4);
    repeat (3) @(posedge sys_clk);
    check({31'h0, tf_req_valid}, 32'h0);
    av_rd(STATE_OFS);
    check(rd, 32'h3412);
    w_base = drive_u.wlog.size();
    r_base = drive_u.rlog.size();
    // slow drive, data-request only on the first poll
    ack_delay  <= 4'h3;
    busy_polls <= 8'h01;
    av_wr(EVENT_OFS, 32'h0a0c);
    av_wr(CTRL_OFS, 32'h2);
    wait_idle();
    ew(TF_FEATURES, 8'h00);
    ew(TF_SECCNT, 8'h0a);
    ew(TF_LBA_MID, 8'h12);
    ew(TF_LBA_HIGH, 8'h34);
    ew(TF_COMMAND, 8'ha5);
    check_writes();
    check_reads(2);
    av_rd(STATE_OFS);
    check(rd, 32'h7856);
    // command block, all registers, high-order on, device/head from block
    ack_delay <= 4'h0;
    foreach (cb[i]) cb[i] = 8'h10 + 8'(i);
    cb[1] = 8'h7f;
    cb[2] = 8'h40;
    cb[3] = 8'h00;
    cb[4] = 8'h01;
    cb[5] = 8'hbf;
    load_cb();
    av_wr(CTRL_OFS, 32'h1);
    wait_idle();
    ew(TF_FEATURES, cb[6]);
    for (int i = 0; i < 8; i++) ew(3'(2 + i % 4), cb[7+i]);
    ew(TF_DEV_HEAD, 8'haf);
    ew(TF_COMMAND, cb[15]);
    check_writes();
    // sparse mask, no high-order, bridge device/head with override
    cb[1] = 8'h61;
    cb[2] = 8'h00;
    cb[3] = 8'h20;
    cb[4] = 8'h00;
    load_cb();
    av_wr(CTRL_OFS, 32'h1);
    wait_idle();
    ew(TF_FEATURES, cb[6]);
    ew(TF_DEV_HEAD, 8'hf0);
    ew(TF_COMMAND, cb[15]);
    check_writes();
    // mid-run reset clears the saved state bytes
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    av_rd(STATE_OFS);
    check(rd, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
